// ==== ecgb_map.vh ====
`ifndef ECGB_MAP_VH
`define ECGB_MAP_VH
`define ECGB_ADDR_W      16
`define ECGB_DIR_A       16'h7F18
`define ECGB_OUT_A       16'h7F19
`define ECGB_IN_A        16'h7F1A
`define ECGB_DIR_B       16'h7F1B
`define ECGB_OUT_B       16'h7F1C
`define ECGB_IN_B        16'h7F1D
`define ECGB_DIR_C       16'h7F1E
`define ECGB_OUT_C       16'h7F1F
`define ECGB_IN_C        16'h7F20
`define ECGB_OUT_D       16'h7F22
`define ECGB_OUT_E       16'h7F23
`define ECGB_RST_VAL     8'h00
`define ECGB_RST_C       6'h00
`define ECGB_RST_E       4'h0
`define ECGB_D_POS_ZERO  0
`define ECGB_D_POS_ONE   1
`define ECGB_D_POS_SEVEN 7
`define ECGB_E_POS_EIGHT 0
`define ECGB_E_POS_NINE  1
`define ECGB_E_POS_TEN   2
`define ECGB_E_POS_ELEVEN 3
`define ECGB_C_MASK      8'h3F
`define ECGB_D_MASK      8'h83
`define ECGB_E_MASK      8'h0F
`endif

// ==== ecgb_pin_sync.v ====
`timescale 1ns/1ps
// Three-stage sampler; a change is accepted once stages two and three agree
module ecgb_pin_sync #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] pinIn,
  output wire [W-1:0] pinLevel
);
  reg [W-1:0] stageOne_reg;
  reg [W-1:0] stageTwo_reg;
  reg [W-1:0] stageThree_reg;
  reg [W-1:0] level_reg;
  integer i;

  always @(posedge ref_clk) begin
    stageOne_reg   <= pinIn;
    stageTwo_reg   <= stageOne_reg;
    stageThree_reg <= stageTwo_reg;
  end

  // Filtered level only moves on agreement, rejecting single-cycle glitches
  always @(posedge ref_clk) begin
    if (rst) begin
      level_reg <= {W{1'b0}};
    end else begin
      for (i = 0; i < W; i = i + 1) begin
        if (stageTwo_reg[i] == stageThree_reg[i]) begin
          level_reg[i] <= stageThree_reg[i];
        end
      end
    end
  end

  assign pinLevel = level_reg;
endmodule // ecgb_pin_sync

// ==== ecgb_gpio_bank.v ====
`timescale 1ns/1ps
`include "ecgb_map.vh"
module ecgb_gpio_bank (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [15:0] memAddr,
  input  wire        memWrite,
  input  wire        memRead,
  input  wire [7:0]  memWrData,
  output wire [7:0]  memRdData,
  input  wire [7:0]  pinAIn,
  output wire [7:0]  pinAOut,
  output wire [7:0]  pinAOe,
  input  wire [7:0]  pinBIn,
  output wire [7:0]  pinBOut,
  output wire [7:0]  pinBOe,
  input  wire [5:0]  pinCIn,
  output wire [5:0]  pinCOut,
  output wire [5:0]  pinCOe,
  input  wire [21:0] altSelect,
  input  wire [21:0] altOutData,
  output wire        fixedOutputZero,
  output wire        fixedOutputOne,
  output wire        fixedOutputSeven,
  output wire        fixedOutputEight,
  output wire        fixedOutputNine,
  output wire        fixedOutputTen,
  output wire        fixedOutputEleven
);
  reg  [7:0]  dirA_reg;
  reg  [7:0]  dirA_next;
  reg  [7:0]  outA_reg;
  reg  [7:0]  outA_next;
  reg  [7:0]  dirB_reg;
  reg  [7:0]  dirB_next;
  reg  [7:0]  outB_reg;
  reg  [7:0]  outB_next;
  reg  [5:0]  dirC_reg;
  reg  [5:0]  dirC_next;
  reg  [5:0]  outC_reg;
  reg  [5:0]  outC_next;
  reg  [7:0]  outD_reg;
  reg  [7:0]  outD_next;
  reg  [3:0]  outE_reg;
  reg  [3:0]  outE_next;
  reg  [7:0]  rdData_reg;
  reg  [7:0]  rdData_next;
  wire [7:0]  pinLevelA;
  wire [7:0]  pinLevelB;
  wire [5:0]  pinLevelC;
  wire        wrDirA;
  wire        wrOutA;
  wire        wrDirB;
  wire        wrOutB;
  wire        wrDirC;
  wire        wrOutC;
  wire        wrOutD;
  wire        wrOutE;

  // Full 16-bit match, so no register shows up at an alias
  function addrHit;
    input [15:0] addr;
    input [15:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // Alternate data swaps the level only; the enable stays with the direction bit
  function [7:0] pinDrive;
    input [7:0] sel;
    input [7:0] alt;
    input [7:0] latch;
    input [7:0] dir;
    begin
      pinDrive = ((sel & alt) | (~sel & latch)) & dir;
    end
  endfunction

  // One sampler per group keeps each group's pins together
  ecgb_pin_sync #(
    .W(8)
  ) uSyncA (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinIn    (pinAIn),
    .pinLevel (pinLevelA)
  );

  ecgb_pin_sync #(
    .W(8)
  ) uSyncB (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinIn    (pinBIn),
    .pinLevel (pinLevelB)
  );

  ecgb_pin_sync #(
    .W(6)
  ) uSyncC (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinIn    (pinCIn),
    .pinLevel (pinLevelC)
  );

  // Input register addresses get no strobe, so writes there change nothing
  assign wrDirA = memWrite & addrHit(memAddr, `ECGB_DIR_A);
  assign wrOutA = memWrite & addrHit(memAddr, `ECGB_OUT_A);
  assign wrDirB = memWrite & addrHit(memAddr, `ECGB_DIR_B);
  assign wrOutB = memWrite & addrHit(memAddr, `ECGB_OUT_B);
  assign wrDirC = memWrite & addrHit(memAddr, `ECGB_DIR_C);
  assign wrOutC = memWrite & addrHit(memAddr, `ECGB_OUT_C);
  assign wrOutD = memWrite & addrHit(memAddr, `ECGB_OUT_D);
  assign wrOutE = memWrite & addrHit(memAddr, `ECGB_OUT_E);

  always @* begin
    dirA_next = dirA_reg;
    outA_next = outA_reg;
    dirB_next = dirB_reg;
    outB_next = outB_reg;
    dirC_next = dirC_reg;
    outC_next = outC_reg;
    outD_next = outD_reg;
    outE_next = outE_reg;
    if (wrDirA) begin
      dirA_next = memWrData;
    end
    if (wrOutA) begin
      outA_next = memWrData;
    end
    if (wrDirB) begin
      dirB_next = memWrData;
    end
    if (wrOutB) begin
      outB_next = memWrData;
    end
    if (wrDirC) begin
      dirC_next = memWrData[5:0];
    end
    if (wrOutC) begin
      outC_next = memWrData[5:0];
    end
    if (wrOutD) begin
      outD_next = memWrData & `ECGB_D_MASK;
    end
    if (wrOutE) begin
      outE_next = memWrData[3:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      dirA_reg <= `ECGB_RST_VAL;
      outA_reg <= `ECGB_RST_VAL;
      dirB_reg <= `ECGB_RST_VAL;
      outB_reg <= `ECGB_RST_VAL;
      dirC_reg <= `ECGB_RST_C;
      outC_reg <= `ECGB_RST_C;
      outD_reg <= `ECGB_RST_VAL;
      outE_reg <= `ECGB_RST_E;
    end else begin
      dirA_reg <= dirA_next;
      outA_reg <= outA_next;
      dirB_reg <= dirB_next;
      outB_reg <= outB_next;
      dirC_reg <= dirC_next;
      outC_reg <= outC_next;
      outD_reg <= outD_next;
      outE_reg <= outE_next;
    end
  end

  // Read data holds between reads; unmapped reads return zero
  always @* begin
    rdData_next = rdData_reg;
    if (memRead) begin
      case (memAddr)
        `ECGB_DIR_A: rdData_next = dirA_reg;
        `ECGB_OUT_A: rdData_next = outA_reg;
        `ECGB_IN_A:  rdData_next = pinLevelA;
        `ECGB_DIR_B: rdData_next = dirB_reg;
        `ECGB_OUT_B: rdData_next = outB_reg;
        `ECGB_IN_B:  rdData_next = pinLevelB;
        `ECGB_DIR_C: rdData_next = {2'b00, dirC_reg};
        `ECGB_OUT_C: rdData_next = {2'b00, outC_reg};
        `ECGB_IN_C:  rdData_next = {2'b00, pinLevelC};
        `ECGB_OUT_D: rdData_next = outD_reg;
        `ECGB_OUT_E: rdData_next = {4'h0, outE_reg};
        default:     rdData_next = `ECGB_RST_VAL;
      endcase
    end
  end

  // Read and write in one cycle: the read sees the old value
  always @(posedge ref_clk) begin
    if (rst) begin
      rdData_reg <= `ECGB_RST_VAL;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign memRdData = rdData_reg;

  // Enables equal the direction bits, even with an alternate function selected
  assign pinAOe  = dirA_reg;
  assign pinBOe  = dirB_reg;
  assign pinCOe  = dirC_reg;
  assign pinAOut = pinDrive(altSelect[7:0], altOutData[7:0], outA_reg, dirA_reg);
  assign pinBOut = pinDrive(altSelect[15:8], altOutData[15:8], outB_reg, dirB_reg);
  assign pinCOut = ((altSelect[21:16] & altOutData[21:16]) | (~altSelect[21:16] & outC_reg))
    & dirC_reg;

  assign fixedOutputZero   = outD_reg[`ECGB_D_POS_ZERO];
  assign fixedOutputOne    = outD_reg[`ECGB_D_POS_ONE];
  assign fixedOutputSeven  = outD_reg[`ECGB_D_POS_SEVEN];
  assign fixedOutputEight  = outE_reg[`ECGB_E_POS_EIGHT];
  assign fixedOutputNine   = outE_reg[`ECGB_E_POS_NINE];
  assign fixedOutputTen    = outE_reg[`ECGB_E_POS_TEN];
  assign fixedOutputEleven = outE_reg[`ECGB_E_POS_ELEVEN];
endmodule // ecgb_gpio_bank

// ==== ecgb_gpio_bank_props.sv ====
`timescale 1ns/1ps
module ecgb_gpio_bank_props (
  input wire        ref_clk,
  input wire        rst,
  input wire [15:0] memAddr,
  input wire        memWrite,
  input wire        memRead,
  input wire [7:0]  memWrData,
  input wire [7:0]  memRdData,
  input wire [7:0]  pinBOut,
  input wire [7:0]  pinBOe,
  input wire [5:0]  pinCOe,
  input wire        fixedOutputZero,
  input wire        fixedOutputSeven,
  input wire        fixedOutputEleven
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_b_dir_wr: assert property (
    memWrite && memAddr == 16'h7F1B |=> pinBOe == $past(memWrData)) else $error("dir B");
  a_b_drive_gate: assert property (
    (pinBOut & ~pinBOe) == 8'h00) else $error("pin B driven while input");
  a_b_in_ro: assert property (
    memWrite && memAddr == 16'h7F1D |=> $stable(pinBOe)) else $error("input B write");
  a_c_dir_wr: assert property (
    memWrite && memAddr == 16'h7F1E |=> pinCOe == $past(memWrData[5:0])) else $error("dir C");
  a_c_dir_rd: assert property (
    memRead && memAddr == 16'h7F1E |=> memRdData == {2'b00, $past(pinCOe)}) else $error("rd C");
  a_c_in_top: assert property (
    memRead && memAddr == 16'h7F20 |=> memRdData[7:6] == 2'b00) else $error("in C top");
  a_d_out_wr: assert property (
    memWrite && memAddr == 16'h7F22 |=> {fixedOutputSeven, fixedOutputZero} ==
      {$past(memWrData[7]), $past(memWrData[0])}) else $error("out D");
  a_e_out_wr: assert property (
    memWrite && memAddr == 16'h7F23 |=> fixedOutputEleven == $past(memWrData[3]))
    else $error("out E");
endmodule // ecgb_gpio_bank_props
bind ecgb_gpio_bank ecgb_gpio_bank_props props (.ref_clk, .rst, .memAddr, .memWrite,
  .memRead, .memWrData, .memRdData, .pinBOut, .pinBOe, .pinCOe, .fixedOutputZero,
  .fixedOutputSeven, .fixedOutputEleven);

// ==== ecgb_board.sv ====
`timescale 1ns/1ps
module ecgb_board #(
  parameter W = 8
) (
  input  wire [W-1:0] pinOut,
  input  wire [W-1:0] pinOe,
  input  wire [W-1:0] level,
  output wire [W-1:0] pinIn
);
  // Board level wins only where the block does not drive
  assign pinIn = (pinOut & pinOe) | (level & ~pinOe);
endmodule // ecgb_board

// ==== test_ecgb_gpio_bank.sv ====
`timescale 1ns/1ps
module test_ecgb_gpio_bank;
  reg         ref_clk = 1'b0, rst = 1'b1, memWrite = 1'b0, memRead = 1'b0;
  reg  [15:0] memAddr = 16'h0000;
  reg  [7:0]  memWrData = 8'h00, levelA = 8'h00, levelB = 8'h00;
  reg  [5:0]  levelC = 6'h00;
  reg  [21:0] altSel = 22'h000000, altData = 22'h000000;
  wire [7:0]  memRdData, pinAIn, pinAOut, pinAOe, pinBIn, pinBOut, pinBOe;
  wire [5:0]  pinCIn, pinCOut, pinCOe;
  wire [6:0]  fixedOut;
  integer     nErrors = 0, samplesChecked = 0;
  localparam [127:0] ADDRS = {16'h7F18, 16'h7F19, 16'h7F1B, 16'h7F1C, 16'h7F1E, 16'h7F1F,
    16'h7F22, 16'h7F23};
  localparam [63:0] MASKS = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h83, 8'h0F};
  ecgb_gpio_bank dut (.ref_clk, .rst, .memAddr, .memWrite, .memRead, .memWrData, .memRdData,
    .pinAIn, .pinAOut, .pinAOe, .pinBIn, .pinBOut, .pinBOe, .pinCIn, .pinCOut, .pinCOe,
    .altSelect(altSel), .altOutData(altData), .fixedOutputZero(fixedOut[0]),
    .fixedOutputOne(fixedOut[1]), .fixedOutputSeven(fixedOut[2]), .fixedOutputEight(fixedOut[3]),
    .fixedOutputNine(fixedOut[4]), .fixedOutputTen(fixedOut[5]), .fixedOutputEleven(fixedOut[6]));
  ecgb_board #(.W(8)) boardA (.pinOut(pinAOut), .pinOe(pinAOe), .level(levelA), .pinIn(pinAIn));
  ecgb_board #(.W(8)) boardB (.pinOut(pinBOut), .pinOe(pinBOe), .level(levelB), .pinIn(pinBIn));
  ecgb_board #(.W(6)) boardC (.pinOut(pinCOut), .pinOe(pinCOe), .level(levelC), .pinIn(pinCIn));
  initial forever #2 ref_clk = ~ref_clk;
  task check(input [7:0] got, input [7:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
        nErrors = nErrors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Idle cycle after each strobe keeps one assignment per time step
  task wr(input [15:0] a, input [7:0] d);
    begin
      {memAddr, memWrData, memWrite} = {a, d, 1'b1};
      @(negedge ref_clk) memWrite = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      {memAddr, memRead} = {a, 1'b1};
      @(negedge ref_clk) memRead = 1'b0;
      check(memRdData, e);
      @(negedge ref_clk);
    end
  endtask
  task reg_access;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rd(ADDRS[i*16 +: 16], 8'h00);
        wr(ADDRS[i*16 +: 16], 8'hFF);
        rd(ADDRS[i*16 +: 16], MASKS[i*8 +: 8]);
      end
      check({1'b0, fixedOut}, 8'h7F);
    end
  endtask
  task refused_writes;
    begin
      wr(16'h7F1D, 8'h00);
      check(pinBOe, 8'hFF);
      rd(16'h7F1D, 8'hFF);
      wr(16'h7F1A, 8'h00);
      rd(16'h7F1A, 8'hFF);
      wr(16'h7F20, 8'h00);
      rd(16'h7F20, 8'h3F);
      wr(16'h7F21, 8'hFF);
      rd(16'h7F21, 8'h00);
    end
  endtask
  task pin_levels;
    begin
      wr(16'h7F18, 8'h00);
      wr(16'h7F1B, 8'h0F);
      wr(16'h7F1C, 8'hA5);
      wr(16'h7F1E, 8'h00);
      check(pinBOut, 8'h05);
      {levelA, levelB, levelC} = {8'h96, 8'h3C, 6'h2A};
      repeat (4) @(negedge ref_clk);
      rd(16'h7F1D, 8'h35);
      rd(16'h7F1A, 8'h96);
      rd(16'h7F20, 8'h2A);
    end
  endtask
  // Alternate data on B and C; enables must still follow the direction bits
  task alt_drive;
    begin
      {altSel, altData} = {22'h3FFF00, 22'h155A00};
      @(negedge ref_clk);
      check(pinBOe, 8'h0F);
      check(pinBOut, 8'h0A);
      check({2'b00, pinCOut}, 8'h00);
      wr(16'h7F1E, 8'h3F);
      check({2'b00, pinCOe}, 8'h3F);
      check({2'b00, pinCOut}, 8'h15);
      wr(16'h7F18, 8'hF0);
      check(pinAOe, 8'hF0);
      check(pinAOut, 8'hF0);
      repeat (4) @(negedge ref_clk);
      rd(16'h7F1D, 8'h3A);
      rd(16'h7F20, 8'h15);
      rd(16'h7F1A, 8'hF6);
    end
  endtask
  task final_report;
    begin
      if (nErrors == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    reg_access;
    refused_writes;
    pin_levels;
    alt_drive;
    final_report;
  end
endmodule // test_ecgb_gpio_bank
